/* hdl/rcf_core_port.sv */
// Purpose: fetch, decode and execute hand-off plus the shared memory port of the core
// Assumes: execute logic holds DATA_REQ until DATA_DONE and pulses FLOW bits for one cycle
// Notes: one bus cycle in flight at a time; data accesses take priority over fetches
`timescale 1ns/1ps
`default_nettype none
`include "rcf_regs.svh"
module rcf_core_port
  import rcf_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  output logic [31:0] MEM_ADDR,
  output logic [1:0] MEM_TRANS,
  output logic [1:0] MEM_SIZE,
  output logic MEM_WRITE,
  output logic [31:0] MEM_WDATA,
  input wire logic [31:0] MEM_RDATA,
  input wire logic MEM_READY,
  input wire rcf_dreq_t DATA_REQ,
  output logic DATA_DONE,
  output logic [31:0] DATA_RDATA,
  input wire rcf_flow_t FLOW,
  output logic EXEC_VALID,
  output logic [31:0] EXEC_INSTR,
  output logic EXEC_COMPACT,
  output logic [31:0] CORE_PC,
  output logic CORE_COMPACT
);
  // force the low address bits of a half or word transfer to zero; bytes pass through
  function automatic logic [31:0] align_addr(input logic [31:0] a, input logic [1:0] sz);
    if (sz == `RCF_SZ_WORD) begin
      align_addr = {a[31:2], 2'b00};
    end else if (sz == `RCF_SZ_HALF) begin
      align_addr = {a[31:1], 1'b0};
    end else begin
      align_addr = a;
    end
  endfunction : align_addr
  // replicate write data across every lane it may land on
  function automatic logic [31:0] lane_wr(input logic [31:0] d, input logic [1:0] sz);
    if (sz == `RCF_SZ_BYTE) begin
      lane_wr = {4{d[7:0]}};
    end else if (sz == `RCF_SZ_HALF) begin
      lane_wr = {2{d[15:0]}};
    end else begin
      lane_wr = d;
    end
  endfunction : lane_wr
  // pick read data off its lane, little-endian only
  function automatic logic [31:0] lane_rd(input logic [31:0] d, input logic [1:0] a,
                                          input logic [1:0] sz);
    logic [31:0] sh;
    sh = d >> {a, 3'b000};
    if (sz == `RCF_SZ_BYTE) begin
      lane_rd = {24'h000000, sh[7:0]};
    end else if (sz == `RCF_SZ_HALF) begin
      lane_rd = {16'h0000, sh[15:0]};
    end else begin
      lane_rd = d;
    end
  endfunction : lane_rd
  // map a compact instruction into a reserved slice of the wide code space
  function automatic logic [31:0] expand16(input logic [15:0] c);
    expand16 = {`RCF_XPAND_PREFIX, c};
  endfunction : expand16
  rcf_bus_st_t st_r, st_nxt;
  logic [31:0] addr_r, addr_nxt;
  logic [1:0] trans_r, trans_nxt;
  logic [1:0] size_r, size_nxt;
  logic write_r, write_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic done_r, done_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic seq_ok_r, seq_ok_nxt;
  logic kill_r, kill_nxt;
  logic [31:0] pc_r, pc_nxt;
  logic compact_r, compact_nxt;
  logic saved_r, saved_nxt;
  logic dec_valid_r, dec_valid_nxt;
  logic [31:0] dec_instr_r, dec_instr_nxt;
  logic dec_compact_r, dec_compact_nxt;
  logic exe_valid_r, exe_valid_nxt;
  logic [31:0] exe_instr_r, exe_instr_nxt;
  logic exe_compact_r, exe_compact_nxt;
  logic bus_done;
  logic flush;
  logic dreq_ok;
  logic dbusy;
  logic drain;
  logic fill;
  always_comb begin
    bus_done = (st_r != RCF_ST_IDLE) && MEM_READY;
    flush = FLOW.bx || FLOW.exc || FLOW.ret;
    // the request is already served while DATA_DONE is high
    dreq_ok = DATA_REQ.valid && (DATA_REQ.op != `RCF_DOP_NONE) && !done_r;
    dbusy = dreq_ok || (st_r == RCF_ST_DREAD) || (st_r == RCF_ST_DWRITE);
    drain = dec_valid_r && !dbusy && !flush;
    fill = (st_r == RCF_ST_FETCH) && bus_done && !kill_r && !flush;
  end
  // program counter and instruction state
  always_comb begin
    pc_nxt = pc_r;
    compact_nxt = compact_r;
    saved_nxt = saved_r;
    if (FLOW.exc) begin
      saved_nxt = compact_r;
      compact_nxt = 1'b0;
      pc_nxt = {FLOW.target[31:2], 2'b00};
    end else if (FLOW.ret) begin
      compact_nxt = saved_r;
      pc_nxt = saved_r ? {FLOW.target[31:1], 1'b0} : {FLOW.target[31:2], 2'b00};
    end else if (FLOW.bx) begin
      // only the state flag and PC move; mode and registers live elsewhere and stay put
      compact_nxt = FLOW.target[0];
      pc_nxt = FLOW.target[0] ? {FLOW.target[31:1], 1'b0} : {FLOW.target[31:2], 2'b00};
    end else if (fill) begin
      pc_nxt = pc_r + (compact_r ? `RCF_STEP_COMPACT : `RCF_STEP_WIDE);
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      pc_r <= 32'h00000000;
      compact_r <= 1'b0;
      saved_r <= 1'b0;
    end else begin
      pc_r <= pc_nxt;
      compact_r <= compact_nxt;
      saved_r <= saved_nxt;
    end
  end
  // bus state machine; one cycle in flight, launched from idle except a swap's write, which follows its read directly
  always_comb begin
    st_nxt = st_r;
    addr_nxt = addr_r;
    trans_nxt = trans_r;
    size_nxt = size_r;
    write_nxt = write_r;
    wdata_nxt = wdata_r;
    done_nxt = 1'b0;
    rdata_nxt = rdata_r;
    seq_ok_nxt = seq_ok_r;
    kill_nxt = kill_r;
    if (flush) begin
      seq_ok_nxt = 1'b0;
      kill_nxt = (st_r == RCF_ST_FETCH) && !bus_done;
    end
    case (st_r)
      RCF_ST_IDLE: begin
        if (dreq_ok) begin
          st_nxt = (DATA_REQ.op == `RCF_DOP_STORE) ? RCF_ST_DWRITE : RCF_ST_DREAD;
          addr_nxt = align_addr(DATA_REQ.addr, DATA_REQ.size);
          trans_nxt = `RCF_CYC_NONSEQ;
          size_nxt = DATA_REQ.size;
          write_nxt = (DATA_REQ.op == `RCF_DOP_STORE);
          wdata_nxt = lane_wr(DATA_REQ.wdata, DATA_REQ.size);
          seq_ok_nxt = 1'b0;
        end else if (!flush && (!dec_valid_r || drain)) begin
          // fetch shares the same bus; a data access breaks the sequential run
          st_nxt = RCF_ST_FETCH;
          addr_nxt = compact_r ? {pc_r[31:1], 1'b0} : {pc_r[31:2], 2'b00};
          trans_nxt = seq_ok_r ? `RCF_CYC_SEQ : `RCF_CYC_NONSEQ;
          size_nxt = compact_r ? `RCF_SZ_HALF : `RCF_SZ_WORD;
          write_nxt = 1'b0;
        end else begin
          trans_nxt = `RCF_CYC_INTERNAL;
        end
      end
      RCF_ST_FETCH: begin
        if (bus_done) begin
          st_nxt = RCF_ST_IDLE;
          trans_nxt = `RCF_CYC_INTERNAL;
          kill_nxt = 1'b0;
          seq_ok_nxt = !kill_r && !flush;
        end
      end
      RCF_ST_DREAD: begin
        if (bus_done) begin
          rdata_nxt = lane_rd(MEM_RDATA, addr_r[1:0], size_r);
          if (DATA_REQ.op == `RCF_DOP_SWAP) begin
            st_nxt = RCF_ST_DWRITE;
            trans_nxt = `RCF_CYC_NONSEQ;
            write_nxt = 1'b1;
            wdata_nxt = lane_wr(DATA_REQ.wdata, size_r);
          end else begin
            st_nxt = RCF_ST_IDLE;
            trans_nxt = `RCF_CYC_INTERNAL;
            done_nxt = 1'b1;
          end
        end
      end
      RCF_ST_DWRITE: begin
        if (bus_done) begin
          st_nxt = RCF_ST_IDLE;
          trans_nxt = `RCF_CYC_INTERNAL;
          write_nxt = 1'b0;
          done_nxt = 1'b1;
        end
      end
      default: begin
        st_nxt = RCF_ST_IDLE;
        trans_nxt = `RCF_CYC_INTERNAL;
      end
    endcase
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      st_r <= RCF_ST_IDLE;
      addr_r <= 32'h00000000;
      trans_r <= `RCF_CYC_INTERNAL;
      size_r <= `RCF_SZ_WORD;
      write_r <= 1'b0;
      wdata_r <= 32'h00000000;
      done_r <= 1'b0;
      rdata_r <= 32'h00000000;
      seq_ok_r <= 1'b0;
      kill_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      addr_r <= addr_nxt;
      trans_r <= trans_nxt;
      size_r <= size_nxt;
      write_r <= write_nxt;
      wdata_r <= wdata_nxt;
      done_r <= done_nxt;
      rdata_r <= rdata_nxt;
      seq_ok_r <= seq_ok_nxt;
      kill_r <= kill_nxt;
    end
  end
  // decode and execute stages
  always_comb begin
    dec_valid_nxt = dec_valid_r;
    dec_instr_nxt = dec_instr_r;
    dec_compact_nxt = dec_compact_r;
    if (flush || drain) begin
      dec_valid_nxt = 1'b0;
    end
    if (fill) begin
      dec_valid_nxt = 1'b1;
      dec_compact_nxt = compact_r;
      dec_instr_nxt = compact_r ? {16'h0000, pc_r[1] ? MEM_RDATA[31:16] : MEM_RDATA[15:0]}
                                : MEM_RDATA;
    end
    exe_valid_nxt = drain;
    exe_compact_nxt = drain ? dec_compact_r : exe_compact_r;
    exe_instr_nxt = exe_instr_r;
    if (drain) begin
      exe_instr_nxt = dec_compact_r ? expand16(dec_instr_r[15:0]) : dec_instr_r;
    end
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      dec_valid_r <= 1'b0;
      dec_instr_r <= 32'h00000000;
      dec_compact_r <= 1'b0;
      exe_valid_r <= 1'b0;
      exe_instr_r <= 32'h00000000;
      exe_compact_r <= 1'b0;
    end else begin
      dec_valid_r <= dec_valid_nxt;
      dec_instr_r <= dec_instr_nxt;
      dec_compact_r <= dec_compact_nxt;
      exe_valid_r <= exe_valid_nxt;
      exe_instr_r <= exe_instr_nxt;
      exe_compact_r <= exe_compact_nxt;
    end
  end
  always_comb begin
    MEM_ADDR = addr_r;
    MEM_TRANS = trans_r;
    MEM_SIZE = size_r;
    MEM_WRITE = write_r;
    MEM_WDATA = wdata_r;
    DATA_DONE = done_r;
    DATA_RDATA = rdata_r;
    EXEC_VALID = exe_valid_r;
    EXEC_INSTR = exe_instr_r;
    EXEC_COMPACT = exe_compact_r;
    CORE_PC = pc_r;
    CORE_COMPACT = compact_r;
  end
  word_align_a: assert property (@(posedge CLK) disable iff (RST)
    (trans_r != `RCF_CYC_INTERNAL && size_r == `RCF_SZ_WORD) |-> addr_r[1:0] == 2'b00)
    else $error("word transfer on a misaligned address");
  half_align_a: assert property (@(posedge CLK) disable iff (RST)
    (trans_r != `RCF_CYC_INTERNAL && size_r == `RCF_SZ_HALF) |-> addr_r[0] == 1'b0)
    else $error("half word transfer on an odd address");
  pc_lowbits_a: assert property (@(posedge CLK) disable iff (RST)
    compact_r ? (pc_r[0] == 1'b0) : (pc_r[1:0] == 2'b00))
    else $error("program counter low bits not clear");
  write_data_a: assert property (@(posedge CLK) disable iff (RST)
    write_r |-> (st_r == RCF_ST_DWRITE && trans_r == `RCF_CYC_NONSEQ))
    else $error("write outside a data cycle");
  exc_wide_a: assert property (@(posedge CLK) disable iff (RST)
    FLOW.exc |=> (!compact_r && saved_r == $past(compact_r)))
    else $error("exception did not enter wide state");
  bx_state_a: assert property (@(posedge CLK) disable iff (RST)
    (FLOW.bx && !FLOW.exc && !FLOW.ret) |=> compact_r == $past(FLOW.target[0]))
    else $error("branch exchange state wrong");
  // a killed fetch keeps the size of the state it was launched in
  fetch_size_a: assert property (@(posedge CLK) disable iff (RST)
    (st_r == RCF_ST_FETCH && !kill_r) |-> size_r == (compact_r ? `RCF_SZ_HALF : `RCF_SZ_WORD))
    else $error("fetch size does not match state");
  byte_lane_a: assert property (@(posedge CLK) disable iff (RST)
    (write_r && size_r == `RCF_SZ_BYTE) |-> wdata_r[31:24] == wdata_r[7:0])
    else $error("byte write not on every lane");
  pipe_step_a: assert property (@(posedge CLK) disable iff (RST)
    (dec_valid_r && !dbusy && !flush) |=> EXEC_VALID ##1 !EXEC_VALID || dec_valid_r)
    else $error("decoded instruction did not reach execute");
  fetch_pc_a: assert property (@(posedge CLK) disable iff (RST)
    fill |=> pc_r == $past(pc_r) + (($past(compact_r)) ? `RCF_STEP_COMPACT : `RCF_STEP_WIDE))
    else $error("program counter did not advance past fetched instruction");

endmodule : rcf_core_port

`default_nettype wire

/* hdl/rcf_regs.svh */
// Purpose: constants for the core fetch and memory port
// Assumes: included by its bare name wherever the constants are needed
// Notes: encodings of size and cycle type are shared with the memory side
`ifndef RCF_REGS_SVH
`define RCF_REGS_SVH

// transfer size on the shared bus
`define RCF_SZ_BYTE 2'h0
`define RCF_SZ_HALF 2'h1
`define RCF_SZ_WORD 2'h2

// bus cycle type
`define RCF_CYC_INTERNAL 2'h0
`define RCF_CYC_NONSEQ 2'h2
`define RCF_CYC_SEQ 2'h3

// data operation requested by the execute stage
`define RCF_DOP_NONE 2'h0
`define RCF_DOP_LOAD 2'h1
`define RCF_DOP_STORE 2'h2
`define RCF_DOP_SWAP 2'h3

// program counter step per state
`define RCF_STEP_WIDE 32'h4
`define RCF_STEP_COMPACT 32'h2

// upper half given to an expanded compact instruction
`define RCF_XPAND_PREFIX 16'hF7F0

`endif

/* hdl/rcf_pkg.sv */
// Purpose: types for the core fetch and memory port
// Assumes: constants live in rcf_regs.svh
// Notes: structs carry the execute-stage requests into the port
package rcf_pkg;

  typedef enum logic [1:0] {
    RCF_ST_IDLE = 2'b00,
    RCF_ST_FETCH = 2'b01,
    RCF_ST_DREAD = 2'b10,
    RCF_ST_DWRITE = 2'b11
  } rcf_bus_st_t;

  typedef struct packed {
    logic valid;
    logic [1:0] op;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } rcf_dreq_t;

  typedef struct packed {
    logic bx;
    logic exc;
    logic ret;
    logic [31:0] target;
  } rcf_flow_t;

endpackage : rcf_pkg

/* verif/rcf_mem_model.sv */
// Purpose: memory and bus model on the far side of the core port
// Assumes: one cycle in flight; a cycle completes at the edge where MEM_READY is high
// Notes: random wait states; read data is scrambled outside the ready cycle
`timescale 1ns/1ps
`default_nettype none
`include "rcf_regs.svh"

module rcf_mem_model
  import rcf_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic [31:0] MEM_ADDR,
  input wire logic [1:0] MEM_TRANS,
  input wire logic [1:0] MEM_SIZE,
  input wire logic MEM_WRITE,
  input wire logic [31:0] MEM_WDATA,
  output logic [31:0] MEM_RDATA,
  output logic MEM_READY
);
  logic [31:0] mem [64];
  logic [1:0] wait_r;
  logic [5:0] idx;
  logic [1:0] lane;
  assign idx = MEM_ADDR[7:2];
  assign lane = MEM_ADDR[1:0];

  always @(posedge CLK) begin
    if (RST) begin
      MEM_READY <= 1'b0;
      MEM_RDATA <= 32'h5A5AA5A5;
      wait_r <= 2'h0;
    end else if (MEM_READY) begin
      MEM_READY <= 1'b0;
      MEM_RDATA <= ~MEM_RDATA;
      if (MEM_WRITE && MEM_TRANS != `RCF_CYC_INTERNAL) begin
        // lanes taken from the wire, so a wrong lane placement corrupts memory
        case (MEM_SIZE)
          `RCF_SZ_BYTE: mem[idx][8*lane +: 8] <= MEM_WDATA[8*lane +: 8];
          `RCF_SZ_HALF: mem[idx][16*lane[1] +: 16] <= MEM_WDATA[16*lane[1] +: 16];
          default: mem[idx] <= MEM_WDATA;
        endcase
      end
    end else if (MEM_TRANS != `RCF_CYC_INTERNAL && wait_r == 2'h0) begin
      MEM_READY <= 1'b1;
      MEM_RDATA <= mem[idx];
      wait_r <= 2'($urandom_range(2, 0));
    end else begin
      MEM_RDATA <= ~MEM_RDATA;
      if (MEM_TRANS != `RCF_CYC_INTERNAL) wait_r <= wait_r - 2'h1;
    end
  end
endmodule : rcf_mem_model
`default_nettype wire

/* verif/tb_risc_core_fetch_and_memory_port.sv */
// Purpose: self-checking bench for the core fetch and memory port
// Assumes: inputs change at rising edges by non-blocking assignment
// Notes: expected values come from the model memory and bench functions
`timescale 1ns/1ps
`default_nettype none
`include "rcf_regs.svh"
`define TB_CHK(a, b) chk(32'(a), 32'(b))

module tb_risc_core_fetch_and_memory_port
  import rcf_pkg::*;
;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [31:0] MEM_ADDR, MEM_WDATA, MEM_RDATA, DATA_RDATA, EXEC_INSTR, CORE_PC;
  logic [1:0] MEM_TRANS, MEM_SIZE;
  logic MEM_WRITE, MEM_READY, DATA_DONE, EXEC_VALID, EXEC_COMPACT, CORE_COMPACT;
  rcf_dreq_t DATA_REQ = '0;
  rcf_flow_t FLOW = '0;
  int err_total = 0;
  int compares = 0;
  int wr_cnt = 0;
  int i;
  logic pdone = 1'b0;
  logic swp;
  // flow table: kind 0 exchange, 1 exception, 2 return
  logic [1:0] fk [6] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2};
  logic [31:0] ft [6] = '{32'h0B, 32'h20, 32'h16, 32'h10, 32'h24, 32'h2A};
  logic fc [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};

  always #25 CLK = ~CLK;

  rcf_core_port dut (.CLK(CLK), .RST(RST), .MEM_ADDR(MEM_ADDR), .MEM_TRANS(MEM_TRANS),
    .MEM_SIZE(MEM_SIZE), .MEM_WRITE(MEM_WRITE), .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA),
    .MEM_READY(MEM_READY), .DATA_REQ(DATA_REQ), .DATA_DONE(DATA_DONE),
    .DATA_RDATA(DATA_RDATA), .FLOW(FLOW), .EXEC_VALID(EXEC_VALID), .EXEC_INSTR(EXEC_INSTR),
    .EXEC_COMPACT(EXEC_COMPACT), .CORE_PC(CORE_PC), .CORE_COMPACT(CORE_COMPACT));

  rcf_mem_model mem_i (.CLK(CLK), .RST(RST), .MEM_ADDR(MEM_ADDR), .MEM_TRANS(MEM_TRANS),
    .MEM_SIZE(MEM_SIZE), .MEM_WRITE(MEM_WRITE), .MEM_WDATA(MEM_WDATA),
    .MEM_RDATA(MEM_RDATA), .MEM_READY(MEM_READY));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task end_of_test;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  task give_up;
    err_total++;
    end_of_test();
  endtask : give_up

  function logic [31:0] f_load(input logic [31:0] w, input logic [31:0] a, input logic [1:0] s);
    if (s == `RCF_SZ_BYTE) return 32'(w[8*a[1:0] +: 8]);
    if (s == `RCF_SZ_HALF) return 32'(w[16*a[1] +: 16]);
    return w;
  endfunction : f_load

  function logic [31:0] f_merge(input logic [31:0] w, input logic [31:0] a,
    input logic [1:0] s, input logic [31:0] d);
    logic [31:0] r;
    r = w;
    if (s == `RCF_SZ_BYTE) r[8*a[1:0] +: 8] = d[7:0];
    else if (s == `RCF_SZ_HALF) r[16*a[1] +: 16] = d[15:0];
    else r = d;
    return r;
  endfunction : f_merge

  function logic [31:0] f_instr(input logic [31:0] a, input logic c);
    logic [31:0] w;
    w = mem_i.mem[a[7:2]];
    return c ? {`RCF_XPAND_PREFIX, w[16*a[1] +: 16]} : w;
  endfunction : f_instr

  // a swap's write follows its read at once; every other completion leaves one idle cycle
  assign swp = MEM_WRITE && DATA_REQ.valid && DATA_REQ.op == `RCF_DOP_SWAP;

  // bus watcher: cycle types, alignment and the idle gap after each completion
  always @(posedge CLK) begin
    if (!RST && pdone) `TB_CHK(MEM_TRANS, swp ? `RCF_CYC_NONSEQ : `RCF_CYC_INTERNAL);
    pdone <= !RST && MEM_TRANS != `RCF_CYC_INTERNAL && MEM_READY;
    if (!RST && MEM_TRANS != `RCF_CYC_INTERNAL && MEM_READY) begin
      `TB_CHK(MEM_TRANS == 2'h1 || MEM_SIZE == 2'h3, 1'b0);
      `TB_CHK(MEM_ADDR[1:0] & {MEM_SIZE == `RCF_SZ_WORD, MEM_SIZE != `RCF_SZ_BYTE}, 2'h0);
      if (MEM_WRITE) wr_cnt++;
    end
  end

  task t_exec(input logic [31:0] pc, input logic c, input int n);
    int k;
    repeat (n) begin
      for (k = 0; k < 60; k++) begin
        if (EXEC_VALID === 1'b1) break;
        @(posedge CLK);
      end
      if (k == 60) give_up();
      `TB_CHK(EXEC_INSTR, f_instr(pc, c));
      `TB_CHK(EXEC_COMPACT, c);
      pc = pc + (c ? `RCF_STEP_COMPACT : `RCF_STEP_WIDE);
      @(posedge CLK);
    end
  endtask : t_exec

  task t_flow(input logic [1:0] k, input logic [31:0] t, input logic c);
    logic [31:0] pa;
    pa = c ? {t[31:1], 1'b0} : {t[31:2], 2'h0};
    @(posedge CLK) FLOW <= '{bx: k == 2'h0, exc: k == 2'h1, ret: k == 2'h2, target: t};
    @(posedge CLK) FLOW <= '0;
    @(posedge CLK);
    `TB_CHK(CORE_PC, pa);
    `TB_CHK(CORE_COMPACT, c);
    t_exec(pa, c, 3);
  endtask : t_flow

  task t_data(input logic [1:0] op, input logic [1:0] sz, input logic [31:0] a,
    input logic [31:0] d);
    logic [31:0] old;
    int k;
    old = mem_i.mem[a[7:2]];
    @(posedge CLK) DATA_REQ <= '{valid: 1'b1, op: op, size: sz, addr: a, wdata: d};
    for (k = 0; k < 40; k++) begin
      @(posedge CLK);
      if (DATA_DONE === 1'b1) break;
    end
    if (k == 40) give_up();
    DATA_REQ.valid <= 1'b0;
    if (op != `RCF_DOP_STORE) `TB_CHK(DATA_RDATA, f_load(old, a, sz));
    `TB_CHK(mem_i.mem[a[7:2]], op == `RCF_DOP_LOAD ? old : f_merge(old, a, sz, d));
  endtask : t_data

  initial begin
    void'($urandom(15));
    for (i = 0; i < 64; i++) mem_i.mem[i] = $urandom;
    mem_i.mem[32] = 32'h44332211;
    repeat (6) @(posedge CLK);
    `TB_CHK(CORE_PC, 32'h0);
    `TB_CHK(MEM_TRANS, `RCF_CYC_INTERNAL);
    `TB_CHK(EXEC_VALID, 1'b0);
    RST <= 1'b0;
    @(posedge CLK);
    t_exec(32'h0, 1'b0, 4);
    for (i = 0; i < 6; i++) t_flow(fk[i], ft[i], fc[i]);
    @(posedge CLK) DATA_REQ <= '{valid: 1'b1, op: `RCF_DOP_NONE, size: `RCF_SZ_WORD,
      addr: 32'h80, wdata: 32'h0};
    repeat (12) begin
      @(posedge CLK);
      `TB_CHK(DATA_DONE, 1'b0);
    end
    `TB_CHK(wr_cnt, 0);
    for (i = 0; i < 4; i++) t_data(`RCF_DOP_LOAD, `RCF_SZ_BYTE, 32'h80 + i, 32'h0);
    t_data(`RCF_DOP_LOAD, `RCF_SZ_HALF, 32'h83, 32'h0);
    t_data(`RCF_DOP_LOAD, `RCF_SZ_WORD, 32'h81, 32'h0);
    t_data(`RCF_DOP_STORE, `RCF_SZ_HALF, 32'h87, 32'hBEEF);
    t_data(`RCF_DOP_SWAP, `RCF_SZ_WORD, 32'h84, 32'hCAFE0123);
    for (i = 0; i < 24; i++) t_data(2'($urandom_range(3, 1)), 2'($urandom_range(2, 0)),
      32'h80 + $urandom_range(127, 0), $urandom);
    end_of_test();
  end
endmodule : tb_risc_core_fetch_and_memory_port
`default_nettype wire
